// ===== rtl/txhw_pkg.sv
/*
 Package for the transmit and hardware setup register bank: offsets,
 field positions, reset values and encodings.
 Assumes a host that reaches the bank over a plain strobe port.
*/
// Summary of operation
// - Two-bit end-alignment field picks 4, 16 or 32 byte ends; 11 reserved.
// - Receive buffers are padded with DWORDs up to the chosen end alignment.
// - Writing 1 to bit 15 clears status FIFO pointers; bit self-clears.
// - Writing 1 to bit 14 clears data FIFO pointers; bit self-clears.
// - With overrun allowance 0, full status FIFO suspends transmission.
// - Status FIFO full interrupt ignores the overrun allowance bit.
// - While enable bit is 1, data in the transmit FIFO is sent.
// - After stop request and actual halt, hardware clears the enable bit.
// - Stop bit lets current frame finish, halts, then clears itself.
// - Writes to the stop bit are ignored while it reads 1.
// - Bit 24 is read-only sampled crossover strap level.
// - Transmit size field bits 19:16, reset 5, 1KB units, 2 to 14.
// - Status FIFO takes 512 bytes, data FIFO the rest of transmit space.
// - Receive FIFOs get 16KB minus the transmit allocation.
// - Clock source field bits 6:5 reset 00 selects internal, external, off.
// - Clock source field only affects clock selection, nothing else.
package txhw_pkg;
    localparam logic [7:0] TXHW_OFS_RX_ALIGN = 8'h6c;
    localparam logic [7:0] TXHW_OFS_TX_CTRL = 8'h70;
    localparam logic [7:0] TXHW_OFS_HW_SETUP = 8'h74;
    localparam int TXHW_ALIGN_LSB = 30;
    localparam int TXHW_STS_FLUSH_BIT = 15;
    localparam int TXHW_DAT_FLUSH_BIT = 14;
    localparam int TXHW_OVR_BIT = 2;
    localparam int TXHW_TXEN_BIT = 1;
    localparam int TXHW_STOP_BIT = 0;
    localparam int TXHW_STRAP_BIT = 24;
    localparam int TXHW_MBO_BIT = 20;
    localparam int TXHW_SIZE_LSB = 16;
    localparam int TXHW_CLK_LSB = 5;
    localparam logic [3:0] TXHW_SIZE_RST = 4'h5;
    localparam logic [3:0] TXHW_SIZE_MIN = 4'h2;
    localparam logic [3:0] TXHW_SIZE_MAX = 4'he;
    localparam logic [4:0] TXHW_TOTAL_KB = 5'h10;
    localparam logic [13:0] TXHW_STS_BYTES = 14'h0200;
    localparam logic [1:0] TXHW_CLK_RST = 2'h0;
    localparam logic [1:0] TXHW_ALIGN_RST = 2'h0;
    typedef enum logic [1:0] {
        TXHW_ALIGN_4 = 2'h0,
        TXHW_ALIGN_16 = 2'h1,
        TXHW_ALIGN_32 = 2'h2,
        TXHW_ALIGN_RSV = 2'h3
    } txhw_align_t;
    typedef enum logic [1:0] {
        TXHW_CLK_INT = 2'h0,
        TXHW_CLK_EXT = 2'h1,
        TXHW_CLK_OFF = 2'h2,
        TXHW_CLK_INT2 = 2'h3
    } txhw_clk_t;
endpackage

// ===== rtl/txhw_pad_if.sv
/*
 Interface between the bank and its end-padding counter.
 Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
interface txhw_pad_if;
    logic [1:0] align;
    logic last;
    logic pad;
    modport bank (output align, output last, input pad);
    modport calc (input align, input last, output pad);
endinterface

// ===== rtl/txhw_pad.sv
/*
 End-padding sequencer: after the last real DWORD of a receive buffer,
 requests pad DWORDs until the chosen end alignment is met.
 Assumes one strobe per delivered DWORD on the same clock.
*/
`timescale 1ns/1ps
module txhw_pad
    import txhw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic dword_tick,
    txhw_pad_if.calc pif
);
    logic [2:0] pos_r;
    logic [2:0] mask;
    logic [2:0] pos_nxt;
    logic pad_r;
    logic aligned;

    // DWORDs per boundary minus one; reserved code falls back to 4 bytes
    assign mask = (pif.align == TXHW_ALIGN_16) ? 3'h3 :
                  (pif.align == TXHW_ALIGN_32) ? 3'h7 : 3'h0;
    assign pos_nxt = (pos_r + 3'h1) & mask;
    assign aligned = (pos_nxt == 3'h0);
    assign pif.pad = pad_r;

    // Position within the alignment block, padding after last DWORD
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pos_r <= 3'h0;
            pad_r <= 1'b0;
        end else if (dword_tick) begin
            pos_r <= pos_nxt;
            pad_r <= (pif.last | pad_r) & ~aligned;
        end
    end

    // Padding must stop on the DWORD that closes the alignment block
    property p_pad_stop;
        @(posedge clock) disable iff (rst)
        dword_tick && aligned |=> !pad_r;
    endproperty
    a_pad_stop: assert property (p_pad_stop) else $error("padding ran past boundary");
endmodule

// ===== rtl/txhw_regs.sv
/*
 Transmit control and hardware setup register bank with the receive
 end-alignment field and the FIFO space split.
 Assumes a host on a plain strobe port on clock; the transmit engine
 reports frame activity and status FIFO state on the same clock.
 The crossover strap is an asynchronous pin.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module txhw_regs
    import txhw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic crossover_strap,
    input wire logic tx_busy,
    input wire logic sts_fifo_full,
    input wire logic rx_dword_tick,
    input wire logic rx_last,
    output logic rx_pad,
    output logic sts_fifo_clear,
    output logic dat_fifo_clear,
    output logic tx_run,
    output logic sts_full_event,
    output logic [13:0] tx_dat_bytes,
    output logic [13:0] rx_bytes,
    output logic [1:0] mii_clock_source,
    output logic [1:0] rx_align
);
    logic [1:0] align_r;
    logic ovr_r;
    logic txen_r;
    logic stop_r;
    logic sflush_r;
    logic dflush_r;
    logic mbo_r;
    logic [3:0] size_r;
    logic [1:0] clk_r;
    logic strap_s1_r;
    logic strap_s2_r;
    logic strap_r;
    logic strap_seen_r;
    logic run_r;
    logic full_r;
    logic [13:0] dat_r;
    logic [13:0] rxb_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wr_align;
    logic wr_tx;
    logic wr_hw;
    logic halted;
    logic [3:0] size_nxt;
    logic [4:0] rx_kb;
    logic run_nxt;
    txhw_pad_if pif();

    // Address decode
    assign wr_align = wr & (addr == TXHW_OFS_RX_ALIGN);
    assign wr_tx = wr & (addr == TXHW_OFS_TX_CTRL);
    assign wr_hw = wr & (addr == TXHW_OFS_HW_SETUP);

    // Halted once a stop is pending and no frame remains in flight
    assign halted = stop_r & ~tx_busy;

    // Out-of-range sizes are clamped, so the split always stays legal
    assign size_nxt = (wdata[TXHW_SIZE_LSB +: 4] < TXHW_SIZE_MIN) ? TXHW_SIZE_MIN :
                      (wdata[TXHW_SIZE_LSB +: 4] > TXHW_SIZE_MAX) ? TXHW_SIZE_MAX :
                      wdata[TXHW_SIZE_LSB +: 4];
    assign rx_kb = TXHW_TOTAL_KB - {1'b0, size_r};

    // Send while enabled; stall on full status FIFO unless overrun allowed
    assign run_nxt = txen_r & ~halted & (ovr_r | ~sts_fifo_full);

    // Read mux; reserved bits read zero
    assign rdata_nxt = ~rd ? 32'h0 :
        (addr == TXHW_OFS_RX_ALIGN) ? {align_r, 30'h0} :
        (addr == TXHW_OFS_TX_CTRL) ? {16'h0, sflush_r, dflush_r, 11'h0, ovr_r, txen_r, stop_r} :
        (addr == TXHW_OFS_HW_SETUP) ? {7'h0, strap_r, 3'h0, mbo_r, size_r,
                                       9'h0, clk_r, 5'h0} : 32'h0;

    assign pif.align = align_r;
    assign pif.last = rx_last;

    txhw_pad u_pad (
        .clock(clock),
        .rst(rst),
        .dword_tick(rx_dword_tick),
        .pif(pif)
    );

    // Receive end-alignment field
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            align_r <= TXHW_ALIGN_RST;
        end else if (wr_align) begin
            align_r <= wdata[TXHW_ALIGN_LSB +: 2];
        end
    end

    // Self-clearing flush strobes, one cycle each
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sflush_r <= 1'b0;
            dflush_r <= 1'b0;
        end else begin
            sflush_r <= wr_tx & wdata[TXHW_STS_FLUSH_BIT];
            dflush_r <= wr_tx & wdata[TXHW_DAT_FLUSH_BIT];
        end
    end

    // Overrun allowance and enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovr_r <= 1'b0;
            txen_r <= 1'b0;
        end else begin
            if (wr_tx) begin
                ovr_r <= wdata[TXHW_OVR_BIT];
            end
            // Hardware halt clear wins over a same-cycle software write
            if (halted) begin
                txen_r <= 1'b0;
            end else if (wr_tx) begin
                txen_r <= wdata[TXHW_TXEN_BIT];
            end
        end
    end

    // Stop request; writes locked out while it is set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stop_r <= 1'b0;
        end else if (halted) begin
            stop_r <= 1'b0;
        end else if (wr_tx && !stop_r) begin
            stop_r <= wdata[TXHW_STOP_BIT];
        end
    end

    // Hardware setup fields; host is trusted to have halted both engines
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mbo_r <= 1'b0;
            size_r <= TXHW_SIZE_RST;
            clk_r <= TXHW_CLK_RST;
        end else if (wr_hw) begin
            mbo_r <= wdata[TXHW_MBO_BIT];
            size_r <= size_nxt;
            clk_r <= wdata[TXHW_CLK_LSB +: 2];
        end
    end

    // Strap synchroniser; the strap bit follows the two-flop synced level on every clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            strap_r <= 1'b0;
            strap_seen_r <= 1'b0;
        end else begin
            strap_s1_r <= crossover_strap;
            strap_s2_r <= strap_s1_r;
            strap_seen_r <= 1'b1;
            if (strap_seen_r == 1'b0 || strap_s2_r != strap_r) begin
                strap_r <= strap_s2_r;
            end
        end
    end

    // Engine-facing outputs, registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            full_r <= 1'b0;
            dat_r <= 14'h0;
            rxb_r <= 14'h0;
        end else begin
            run_r <= run_nxt;
            full_r <= sts_fifo_full;
            dat_r <= {size_r, 10'h0} - TXHW_STS_BYTES;
            rxb_r <= {rx_kb[3:0], 10'h0};
        end
    end

    // Read data stands the cycle after the read strobe only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pad request registered to keep the output straight from a flop
    logic pad_q_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pad_q_r <= 1'b0;
        end else begin
            pad_q_r <= pif.pad;
        end
    end

    assign rdata = rdata_r;
    assign rx_pad = pad_q_r;
    assign sts_fifo_clear = sflush_r;
    assign dat_fifo_clear = dflush_r;
    assign tx_run = run_r;
    assign sts_full_event = full_r;
    assign tx_dat_bytes = dat_r;
    assign rx_bytes = rxb_r;
    assign mii_clock_source = clk_r;
    assign rx_align = align_r;

    // Checks on the halt handshake, flushes, split and clock select
    property p_stop_clear;
        @(posedge clock) disable iff (rst)
        stop_r && !tx_busy |=> !stop_r && !txen_r;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("halt did not clear bits");

    property p_stop_lock;
        @(posedge clock) disable iff (rst)
        stop_r && tx_busy |=> stop_r;
    endproperty
    a_stop_lock: assert property (p_stop_lock) else $error("stop bit dropped early");

    property p_stop_set;
        @(posedge clock) disable iff (rst)
        wr_tx && wdata[TXHW_STOP_BIT] && !stop_r |=> stop_r;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop request lost");

    // Frame in flight keeps running while the stop is pending
    property p_frame_finish;
        @(posedge clock) disable iff (rst)
        stop_r && tx_busy && txen_r && !sts_fifo_full |=> tx_run;
    endproperty
    a_frame_finish: assert property (p_frame_finish) else $error("frame cut by stop");

    // Back-to-back flush writes legally stretch the pulse
    property p_sflush;
        @(posedge clock) disable iff (rst)
        wr_tx && wdata[TXHW_STS_FLUSH_BIT] ##1 !(wr_tx && wdata[TXHW_STS_FLUSH_BIT])
        |-> sts_fifo_clear ##1 !sts_fifo_clear;
    endproperty
    a_sflush: assert property (p_sflush) else $error("status flush not one cycle");

    property p_dflush;
        @(posedge clock) disable iff (rst)
        wr_tx && wdata[TXHW_DAT_FLUSH_BIT] ##1 !(wr_tx && wdata[TXHW_DAT_FLUSH_BIT])
        |-> dat_fifo_clear ##1 !dat_fifo_clear;
    endproperty
    a_dflush: assert property (p_dflush) else $error("data flush not one cycle");

    property p_suspend;
        @(posedge clock) disable iff (rst)
        !ovr_r && sts_fifo_full |=> !tx_run;
    endproperty
    a_suspend: assert property (p_suspend) else $error("sent with full status FIFO");

    property p_full_evt;
        @(posedge clock) disable iff (rst)
        sts_fifo_full |=> sts_full_event;
    endproperty
    a_full_evt: assert property (p_full_evt) else $error("full event missed");

    property p_run;
        @(posedge clock) disable iff (rst)
        txen_r && !stop_r && ovr_r |=> tx_run;
    endproperty
    a_run: assert property (p_run) else $error("enabled but not running");

    property p_size;
        @(posedge clock) disable iff (rst)
        size_r >= TXHW_SIZE_MIN && size_r <= TXHW_SIZE_MAX;
    endproperty
    a_size: assert property (p_size) else $error("size out of range");

    // Data FIFO is whole kilobytes less the 512-byte status FIFO
    property p_dat_split;
        @(posedge clock) disable iff (rst)
        1'b1 |=> tx_dat_bytes == {$past(size_r) - 4'h1, 10'h200};
    endproperty
    a_dat_split: assert property (p_dat_split) else $error("data FIFO size wrong");

    property p_split;
        @(posedge clock) disable iff (rst)
        ##1 $stable(size_r) |=> ({4'h0, rx_bytes} + {4'h0, tx_dat_bytes}
        + {4'h0, TXHW_STS_BYTES}) == 18'h04000;
    endproperty
    a_split: assert property (p_split) else $error("split not 16KB");

    property p_clk_hold;
        @(posedge clock) disable iff (rst)
        !wr_hw |=> $stable(mii_clock_source);
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock source moved");

    property p_clk_sel;
        @(posedge clock) disable iff (rst)
        wr_hw |=> mii_clock_source == $past(wdata[TXHW_CLK_LSB +: 2]);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock source write lost");

    // Strap bit is read-only: a write must not disturb the synced level
    property p_strap_ro;
        @(posedge clock) disable iff (rst)
        wr_hw |=> strap_r == $past(strap_s2_r);
    endproperty
    a_strap_ro: assert property (p_strap_ro) else $error("strap moved by write");

    property p_align_wr;
        @(posedge clock) disable iff (rst)
        wr_align |=> rx_align == $past(wdata[TXHW_ALIGN_LSB +: 2]);
    endproperty
    a_align_wr: assert property (p_align_wr) else $error("alignment write lost");

    // Read data only stands in the slot after a read strobe
    property p_rd_idle;
        @(posedge clock) disable iff (rst)
        !rd |=> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

// ===== testbench/txhw_engine_model.sv
/*
 Transmit engine stand-in: frame activity and status FIFO fill level.
 Assumes the bench pulses frame_req and fill_req on the clock.
*/
`timescale 1ns/1ps
module txhw_engine_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic frame_req,
    input wire logic fill_req,
    input wire logic sts_fifo_clear,
    output logic tx_busy,
    output logic sts_fifo_full
);
    logic [3:0] frame_cnt_r;
    // A frame holds the engine busy for 12 cycles, long enough to race a stop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_cnt_r <= 4'h0;
            sts_fifo_full <= 1'b0;
        end else begin
            if (frame_req) frame_cnt_r <= 4'hc;
            else if (frame_cnt_r != 4'h0) frame_cnt_r <= frame_cnt_r - 4'h1;
            // Flush empties the status FIFO, so full drops
            if (sts_fifo_clear) sts_fifo_full <= 1'b0;
            else if (fill_req) sts_fifo_full <= 1'b1;
        end
    end
    assign tx_busy = (frame_cnt_r != 4'h0);
endmodule

// ===== testbench/tx_and_hw_config_regs_tb_top.sv
/*
 Self-checking bench for the transmit and hardware setup bank.
 Assumes the bank answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module tx_and_hw_config_regs_tb_top;
    import txhw_pkg::*;
    logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, strap = 1'b0;
    logic frame_req = 1'b0, fill_req = 1'b0, tx_busy, sts_full, rx_pad;
    logic tick_dw = 1'b0, last_dw = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic sts_clr, dat_clr, tx_run, full_ev;
    logic [13:0] dat_bytes, rx_bytes;
    logic [1:0] clk_src, rx_align;
    int num_errors = 0, samples_checked = 0, cyc = 0;
    always #5 clock = ~clock;
    txhw_regs dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .crossover_strap(strap), .tx_busy(tx_busy), .sts_fifo_full(sts_full),
        .rx_dword_tick(tick_dw), .rx_last(last_dw), .rx_pad(rx_pad), .sts_fifo_clear(sts_clr),
        .dat_fifo_clear(dat_clr), .tx_run(tx_run), .sts_full_event(full_ev),
        .tx_dat_bytes(dat_bytes), .rx_bytes(rx_bytes), .mii_clock_source(clk_src),
        .rx_align(rx_align));
    txhw_engine_model eng (.clock(clock), .rst(rst), .frame_req(frame_req),
        .fill_req(fill_req), .sts_fifo_clear(sts_clr), .tx_busy(tx_busy),
        .sts_fifo_full(sts_full));
    task automatic summarize;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // Step just past the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Bus cycles: change after the edge, hold through the sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Reset values, and an unmapped place that stays empty
    task automatic t_reset;
        rd_reg(TXHW_OFS_TX_CTRL, v); chk(v, 32'h0);
        rd_reg(TXHW_OFS_HW_SETUP, v); chk(v, 32'h0005_0000);
        chk(32'(dat_bytes), 32'd4608);
        chk(32'(rx_bytes), 32'd11264);
        wr_reg(8'h40, 32'hffff_ffff);
        rd_reg(8'h40, v); chk(v, 32'h0);
        $display("test reset done");
    endtask
    // Enable, full status FIFO with and without overrun allowance, flushes
    task automatic t_run;
        wr_reg(TXHW_OFS_TX_CTRL, 32'h2);
        tick(2); chk(32'(tx_run), 32'h1);
        @(posedge clock) fill_req <= 1'b1;
        @(posedge clock) fill_req <= 1'b0;
        tick(3); chk(32'(tx_run), 32'h0);
        chk(32'(full_ev), 32'h1);
        wr_reg(TXHW_OFS_TX_CTRL, 32'h6);
        tick(3); chk(32'(tx_run), 32'h1);
        chk(32'(full_ev), 32'h1);
        wr_reg(TXHW_OFS_TX_CTRL, 32'h8006);
        #1 chk({sts_clr, dat_clr}, 32'h2);
        wr_reg(TXHW_OFS_TX_CTRL, 32'h4006);
        #1 chk({sts_clr, dat_clr}, 32'h1);
        tick(2); chk(32'(sts_full), 32'h0);
        rd_reg(TXHW_OFS_TX_CTRL, v); chk(v, 32'h6);
        $display("test run done");
    endtask
    // Stop during a frame; stop-bit writes ignored until the halt
    task automatic t_stop;
        @(posedge clock) frame_req <= 1'b1;
        @(posedge clock) frame_req <= 1'b0;
        wr_reg(TXHW_OFS_TX_CTRL, 32'h3);
        wr_reg(TXHW_OFS_TX_CTRL, 32'h2);
        rd_reg(TXHW_OFS_TX_CTRL, v); chk(v, 32'h3);
        chk(32'(tx_run), 32'h1);
        for (int i = 0; i < 40 && tx_busy; i++) tick(1);
        tick(3);
        rd_reg(TXHW_OFS_TX_CTRL, v); chk(v, 32'h0);
        chk(32'(tx_run), 32'h0);
        $display("test stop done");
    endtask
    // Transmitter is halted here, so the setup register may be written
    task automatic t_hw;
        logic [3:0] sz [4] = '{4'h1, 4'h2, 4'he, 4'hf};
        logic [3:0] ex [4] = '{4'h2, 4'h2, 4'he, 4'he};
        strap <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(TXHW_OFS_HW_SETUP, {7'h0, 1'b0, 3'h0, 1'b1, sz[i], 9'h0, 2'(i), 5'h0});
            tick(3);
            chk(32'(dat_bytes), 32'(ex[i]) * 1024 - 512);
            chk(32'(rx_bytes), (16 - 32'(ex[i])) * 1024);
            chk(32'(clk_src), 32'(i));
            rd_reg(TXHW_OFS_HW_SETUP, v);
            chk(v & 32'h0110_0060, 32'h0110_0000 | (32'(i) << 5));
            if (sz[i] == ex[i]) chk(32'(v[19:16]), 32'(ex[i]));
            chk(32'(v[20]), 32'h1);
        end
        chk(32'(rx_align), 32'h0);
        strap <= 1'b0;
        tick(4);
        rd_reg(TXHW_OFS_HW_SETUP, v); chk(32'(v[24]), 32'h0);
        $display("test hw done");
    endtask
    // End alignment codes; the reserved code is never written
    task automatic t_align;
        for (int i = 0; i < 3; i++) begin
            wr_reg(TXHW_OFS_RX_ALIGN, 32'(i) << 30);
            tick(1);
            chk(32'(rx_align), 32'(i));
            rd_reg(TXHW_OFS_RX_ALIGN, v); chk(v[31:30], 32'(i));
        end
        chk(32'(clk_src), 32'h3);
        $display("test align done");
    endtask
    // One receive DWORD, spaced so the two-cycle pad latency settles
    task automatic rx_dw(input logic is_last);
        @(posedge clock);
        tick_dw <= 1'b1;
        last_dw <= is_last;
        @(posedge clock);
        tick_dw <= 1'b0;
        last_dw <= 1'b0;
        tick(2);
    endtask
    // Pad DWORDs fill a buffer out to its end alignment
    task automatic t_pad;
        int n;
        // 32-byte ends: 3 real DWORDs need 5 pad DWORDs to reach 8
        n = 0;
        rx_dw(1'b0);
        rx_dw(1'b0);
        rx_dw(1'b1);
        chk(32'(rx_pad), 32'h1);
        while (rx_pad && n < 12) begin
            rx_dw(1'b0);
            n++;
        end
        chk(32'(n), 32'd5);
        // 16-byte ends: 5 real DWORDs need 3 pad DWORDs to reach 8
        wr_reg(TXHW_OFS_RX_ALIGN, 32'h4000_0000);
        n = 0;
        repeat (4) rx_dw(1'b0);
        rx_dw(1'b1);
        while (rx_pad && n < 12) begin
            rx_dw(1'b0);
            n++;
        end
        chk(32'(n), 32'd3);
        // 4-byte ends never need padding
        wr_reg(TXHW_OFS_RX_ALIGN, 32'h0);
        rx_dw(1'b1);
        chk(32'(rx_pad), 32'h0);
        $display("test pad done");
    endtask
    // Hang guard sized well above the expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        tick(16);
        @(negedge clock) rst = 1'b0;
        t_reset();
        t_run();
        t_stop();
        t_hw();
        t_align();
        t_pad();
        summarize();
    end
endmodule
